// ---- src/mth_pkg.sv ----
// Package of constants and types for the measurement trigger handshake
package mth_pkg;
  localparam int unsigned MTH_MAX_OUTSTANDING = 4;
  localparam logic MTH_READY_RST = 1'b1;
  localparam logic MTH_ERR_RST = 1'b0;
  localparam logic MTH_COLOUR_RST = 1'b1;
  localparam logic MTH_PULSE_RST = 1'b0;
  typedef enum logic [1:0] {
    MTH_IDLE = 2'b00,
    MTH_EXPOSE = 2'b01,
    MTH_LOAD = 2'b10
  } mth_cam_e;
endpackage

// ---- src/mth_sync.sv ----
// Two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mth_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous input
  output logic [WIDTH-1:0] q // Synchronised output
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end
  assign q = q_r;
endmodule // mth_sync
`default_nettype wire

// ---- src/mth_trigger.sv ----
// Measurement trigger handshake: ready, error and exposure-done logic
`timescale 1ns/1ps
`default_nettype none
module mth_trigger
  import mth_pkg::*;
#(
  parameter int MAX_OUT = mth_pkg::MTH_MAX_OUTSTANDING
) (
  input wire logic clk, // 40 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic trig_pin, // Parallel trigger pin, asynchronous
  input wire logic trig_cmd, // Command trigger pulse, same clock
  input wire logic cmd_is_fieldbus, // Command arrives over fieldbus
  input wire logic exposure_end, // Camera exposure finished pulse
  input wire logic load_done, // Image load into camera buffer done pulse
  input wire logic proc_done, // One measurement processing finished pulse
  input wire logic flow_multi_cam, // Flow has several camera inputs
  input wire logic flow_hdr, // Flow has an HDR input unit
  input wire logic flow_repeat_cam, // Branching repeats a camera input
  input wire logic scene_change, // Scene change pulse
  output logic ready, // Can accept next trigger
  output logic trig_accept, // Trigger accepted pulse
  output logic error_out, // Parallel error output
  output logic exposure_done_out, // Exposure done pulse
  output logic multi_input_en, // Early ready release permitted
  output logic image_default // No image yet, default colour image
);
  import mth_pkg::*;

  // Count width follows MAX_OUT; the upper bound keeps the counter small
  if (MAX_OUT < 1 || MAX_OUT > 255) begin : g_bad_max_out
    $error("MAX_OUT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger intake
  logic trig_sync;
  logic trig_prev_r;
  logic trig_prev_nxt;
  logic trig_evt;

  mth_sync #(.WIDTH(1)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(trig_pin),
    .q(trig_sync)
  );

  // Edge taken on the synchronised copy only
  assign trig_prev_nxt = trig_sync;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_prev_nxt;
    end
  end
  assign trig_evt = (trig_sync & ~trig_prev_r) | trig_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Early release allowed only for a single plain camera input fed by pins/fieldbus
  logic cmd_seen_r;
  logic cmd_seen_nxt;
  always_comb begin
    cmd_seen_nxt = cmd_seen_r;
    if (scene_change) begin
      cmd_seen_nxt = 1'b0;
    end
    if (trig_cmd && !cmd_is_fieldbus) begin
      cmd_seen_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_seen_r <= 1'b0;
    end else begin
      cmd_seen_r <= cmd_seen_nxt;
    end
  end
  assign multi_input_en = ~(flow_multi_cam | flow_hdr | flow_repeat_cam | cmd_seen_r);

  ////////////////////////////////////////////////////////////////////////////
  // Camera phase, outstanding count, ready
  localparam int CW = $clog2(MAX_OUT + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MAX_OUT);
  mth_cam_e cam_r, cam_nxt;
  logic [CW-1:0] out_r, out_nxt;
  logic ready_r, ready_nxt;
  logic err_r, err_nxt;
  logic exp_r, exp_nxt;
  logic acc_r, acc_nxt;
  logic dflt_r, dflt_nxt;
  logic take;

  assign take = trig_evt & ready_r;

  always_comb begin
    cam_nxt = cam_r;
    out_nxt = out_r;
    exp_nxt = 1'b0;
    acc_nxt = take;
    err_nxt = trig_evt & ~ready_r;
    dflt_nxt = dflt_r;
    unique case (cam_r)
      MTH_IDLE: begin
        if (take) begin
          cam_nxt = MTH_EXPOSE;
        end
      end
      MTH_EXPOSE: begin
        if (exposure_end) begin
          cam_nxt = MTH_LOAD;
          exp_nxt = 1'b1;
        end
      end
      MTH_LOAD: begin
        if (load_done) begin
          cam_nxt = MTH_IDLE;
          dflt_nxt = 1'b0;
        end
      end
      default: cam_nxt = MTH_IDLE;
    endcase
    // Scene change wins over a load in the same cycle: the new scene has no image yet
    if (scene_change) begin
      dflt_nxt = 1'b1;
    end
    // Count measurements whose processing is still running
    if (take && !(proc_done && out_r != '0)) begin
      out_nxt = out_r + CW'(1);
    end else if (!take && proc_done && out_r != '0) begin
      out_nxt = out_r - CW'(1);
    end
    // Without early release the whole processing must end before ready
    if (cam_nxt != MTH_IDLE) begin
      ready_nxt = 1'b0;
    end else if (out_nxt >= CNT_MAX) begin
      ready_nxt = 1'b0;
    end else if (!multi_input_en && out_nxt != '0) begin
      ready_nxt = 1'b0;
    end else begin
      ready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cam_r <= MTH_IDLE;
      out_r <= '0;
      ready_r <= MTH_READY_RST;
      err_r <= MTH_ERR_RST;
      exp_r <= MTH_PULSE_RST;
      acc_r <= MTH_PULSE_RST;
      dflt_r <= MTH_COLOUR_RST;
    end else begin
      cam_r <= cam_nxt;
      out_r <= out_nxt;
      ready_r <= ready_nxt;
      err_r <= err_nxt;
      exp_r <= exp_nxt;
      acc_r <= acc_nxt;
      dflt_r <= dflt_nxt;
    end
  end

  assign ready = ready_r;
  assign error_out = err_r;
  assign exposure_done_out = exp_r;
  assign trig_accept = acc_r;
  assign image_default = dflt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_take;
    trig_evt && ready_r;
  endsequence

  chk_ready_drop: assert property (@(posedge clk) disable iff (!resetn)
    s_take |=> !ready_r) else $error("ready not dropped after trigger");
  chk_err_on_busy: assert property (@(posedge clk) disable iff (!resetn)
    trig_evt && !ready_r |=> error_out) else $error("missing error pulse");
  chk_no_false_err: assert property (@(posedge clk) disable iff (!resetn)
    !(trig_evt && !ready_r) |=> !error_out) else $error("spurious error");
  chk_accept_gate: assert property (@(posedge clk) disable iff (!resetn)
    trig_accept |-> $past(ready_r)) else $error("accept while not ready");
  chk_exp_pulse: assert property (@(posedge clk) disable iff (!resetn)
    exposure_done_out |-> cam_r == MTH_LOAD && !$past(exposure_done_out))
    else $error("exposure done misplaced");
  chk_load_ready: assert property (@(posedge clk) disable iff (!resetn)
    cam_r == MTH_LOAD && load_done && multi_input_en && !scene_change
    && out_r < CNT_MAX && !proc_done && !trig_evt |=> ready_r)
    else $error("ready not raised after load");
  chk_limit_hold: assert property (@(posedge clk) disable iff (!resetn)
    out_r >= CNT_MAX |-> !ready_r) else $error("ready high at limit");
  chk_mi_disable: assert property (@(posedge clk) disable iff (!resetn)
    (flow_multi_cam || flow_hdr || flow_repeat_cam) |-> !multi_input_en)
    else $error("early release not disabled");
  chk_default_img: assert property (@(posedge clk) disable iff (!resetn)
    scene_change |=> image_default) else $error("default image not restored");

  // Camera phase steps that the pulse and image checks key on
  sequence s_expo_end;
    cam_r == MTH_EXPOSE && exposure_end;
  endsequence
  sequence s_load_clean;
    cam_r == MTH_LOAD && load_done && !scene_change;
  endsequence

  chk_expo_follow: assert property (@(posedge clk) disable iff (!resetn)
    s_expo_end |=> exposure_done_out)
    else $error("exposure done missing");
  chk_image_kept: assert property (@(posedge clk) disable iff (!resetn)
    s_load_clean |=> !image_default)
    else $error("default image after load");
  chk_busy_low: assert property (@(posedge clk) disable iff (!resetn)
    cam_r != MTH_IDLE |-> !ready_r)
    else $error("ready high during capture");
  // Ready was decided from last cycle's enable, so look one cycle back
  chk_no_early: assert property (@(posedge clk) disable iff (!resetn)
    !$past(multi_input_en) && out_r != '0 |-> !ready_r)
    else $error("early release while disabled");
  chk_cnt_bound: assert property (@(posedge clk) disable iff (!resetn)
    out_r <= CNT_MAX)
    else $error("outstanding count overrun");
  chk_err_excl: assert property (@(posedge clk) disable iff (!resetn)
    error_out |-> !trig_accept)
    else $error("error and accept together");
endmodule // mth_trigger
`default_nettype wire

// ---- tb/mth_plc.sv ----
// Controller-side model that issues command triggers
`timescale 1ns/1ps
`default_nettype none
module mth_plc (
  input wire logic ready, // Device can take a trigger
  input wire logic go, // Request a polite trigger
  input wire logic rude, // Trigger regardless of ready
  output logic trig_cmd // Command trigger pulse
);
  // Waiting for ready also keeps the trigger rate at the result rate
  assign trig_cmd = (go & ready) | rude;
endmodule // mth_plc
`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench for the measurement trigger handshake
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mth_pkg::*;
  logic clk, resetn, trig_pin, trig_cmd, fb, go, rude, rdy, acc, err, exd, mie, img;
  logic [3:0] ev;
  logic [2:0] fl;
  int miscompares, comparisons, cycles;
  mth_trigger #(.MAX_OUT(2)) i_dut (.clk(clk), .resetn(resetn), .trig_pin(trig_pin),
    .trig_cmd(trig_cmd), .cmd_is_fieldbus(fb), .exposure_end(ev[0]), .load_done(ev[1]),
    .proc_done(ev[2]), .flow_multi_cam(fl[0]), .flow_hdr(fl[1]), .flow_repeat_cam(fl[2]),
    .scene_change(ev[3]), .ready(rdy), .trig_accept(acc), .error_out(err),
    .exposure_done_out(exd), .multi_input_en(mie), .image_default(img));
  mth_plc i_plc (.ready(rdy), .go(go), .rude(rude), .trig_cmd(trig_cmd));
  // Bench models one camera cabled to port zero over one cable
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string n, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask
  // Event pulses: 0 exposure, 1 load, 2 processing, 3 scene
  task automatic p(input int k);
    ev[k] = 1'h1;
    @(negedge clk);
    ev = 4'h0;
  endtask
  task automatic tr();
    go = 1'h1;
    @(negedge clk);
    go = 1'h0;
    chk("accept", 1'h1, acc);
    chk("ready_drop", 1'h0, rdy);
    chk("no_err", 1'h0, err);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_basic();
    chk("rst_img", MTH_COLOUR_RST, img);
    p(0);
    chk("stray_expo", 1'h0, exd);
    tr();
    repeat (3) @(negedge clk);
    p(0);
    chk("expo", 1'h1, exd);
    chk("held_low", 1'h0, rdy);
    p(1);
    chk("ready_up", 1'h1, rdy);
    chk("img_loaded", 1'h0, img);
    p(2);
    p(3);
    chk("img_scene", 1'h1, img);
  endtask
  task automatic t_err();
    tr();
    rude = 1'h1;
    @(negedge clk);
    rude = 1'h0;
    chk("err", 1'h1, err);
    chk("refused", 1'h0, acc);
    p(0);
    p(1);
    p(2);
  endtask
  task automatic t_limit();
    tr();
    p(0);
    p(1);
    chk("early", 1'h1, rdy);
    tr();
    p(0);
    p(1);
    chk("full", 1'h0, rdy);
    p(2);
    chk("one_left", 1'h1, rdy);
    p(2);
    chk("drained", 1'h1, rdy);
  endtask
  task automatic t_multi();
    for (int k = 0; k < 3; k++) begin
      fl = 3'h1 << k;
      @(negedge clk);
      chk("flow_off", 1'h0, mie);
    end
    tr();
    p(0);
    p(1);
    chk("no_early", 1'h0, rdy);
    p(2);
    chk("late", 1'h1, rdy);
    fl = 3'h0;
    fb = 1'h0;
    tr();
    fb = 1'h1;
    chk("cmd_off", 1'h0, mie);
    p(0);
    p(1);
    p(2);
    p(3);
    chk("scene_on", 1'h1, mie);
  endtask
  task automatic t_pin();
    trig_pin = 1'h1;
    for (int i = 0; i < 8 && acc !== 1'h1; i++) @(negedge clk);
    chk("pin_accept", 1'h1, acc);
    trig_pin = 1'h0;
    p(0);
    p(1);
    chk("pin_load", 1'h1, rdy);
    p(2);
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {resetn, trig_pin, go, rude, ev, fl} = '0;
    fb = 1'h1;
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    @(negedge clk);
    t_basic();
    t_err();
    t_limit();
    t_multi();
    t_pin();
    results();
  end
endmodule // tb_top
`default_nettype wire
